// ---- rtl/wake_cfg_pkg.sv ----
// Purpose: Constants and types for the standby wake source mode block.
// Assumes: Wishbone classic slave, 32-bit data, byte addresses.
// Notes:   Four sources share one mode register, one byte lane each.
// How it works
// - Three-bit select: low, high, fall, rise, both
// - Read-only two-bit edge status per source
// - Edge status meaningful only in both-edge mode
// - Request clear also clears recorded edge status
// - Enable bit gates source as release input
// - One byte lane per source, fixed bit fields
package wake_cfg_pkg;

	//--------------------------------------------------------------
	// Register map
	//--------------------------------------------------------------
	localparam logic [3:0] OFS_MODE   = 4'h0;
	localparam logic [3:0] OFS_CLEAR  = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] OFS_IRQ_EN = 4'hC;

	//--------------------------------------------------------------
	// Field layout within one byte lane
	//--------------------------------------------------------------
	localparam int SEL_LSB  = 4;
	localparam int EDGE_LSB = 2;
	localparam int EN_BIT   = 0;
	localparam int LANE_W   = 8;
	localparam int NUM_SRC  = 4;
	localparam logic [4:0] FIRST_SRC_CODE = 5'h08;

	//--------------------------------------------------------------
	// Detection select codes and reset values
	//--------------------------------------------------------------
	localparam logic [2:0] SEL_LOW   = 3'h0;
	localparam logic [2:0] SEL_HIGH  = 3'h1;
	localparam logic [2:0] SEL_FALL  = 3'h2;
	localparam logic [2:0] SEL_RISE  = 3'h3;
	localparam logic [2:0] SEL_BOTH  = 3'h4;
	localparam logic [2:0] SEL_RESET = 3'h2;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;

	typedef struct packed {
		logic [2:0] sel;
		logic [1:0] edge_st;
		logic       en;
		logic       prev;
		logic       wake;
	} src_state_t;

endpackage

// ---- rtl/wake_detector.sv ----
// Purpose: One wake source: level or edge detection and edge record.
// Assumes: Source input is synchronous to clk_i.
// Notes:   Select and enable are held by this cell.
`timescale 1ns/1ps
module wake_detector
	import wake_cfg_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       src_i,
	input  wire logic       sel_we_i,
	input  wire logic [2:0] sel_i,
	input  wire logic       en_we_i,
	input  wire logic       en_i,
	input  wire logic       clr_i,
	output logic [2:0]      sel_o,
	output logic [1:0]      edge_o,
	output logic            en_o,
	output logic            wake_o
);
	src_state_t s_r;
	src_state_t s_nxt;
	logic       rise;
	logic       fall;
	logic       hit;

	always_comb
	begin
		rise  = src_i & ~s_r.prev;
		fall  = ~src_i & s_r.prev;
		s_nxt = s_r;
		s_nxt.prev = src_i;
		if (sel_we_i)
			s_nxt.sel = sel_i;
		if (en_we_i)
			s_nxt.en = en_i;
		case (s_r.sel)
			SEL_LOW:  hit = ~src_i;
			SEL_HIGH: hit = src_i;
			SEL_FALL: hit = fall;
			SEL_RISE: hit = rise;
			SEL_BOTH: hit = rise | fall;
			default:  hit = 1'b0;
		endcase
		s_nxt.wake = s_r.en & hit;
		if (clr_i)
			s_nxt.edge_st = 2'h0;
		if (s_r.en && s_r.sel == SEL_BOTH)
			s_nxt.edge_st = s_nxt.edge_st | (rise ? EDGE_RISE : 2'h0)
				| (fall ? EDGE_FALL : 2'h0);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_r      <= '0;
			s_r.sel  <= SEL_RESET;
		end
		else
			s_r <= s_nxt;
	end

	assign sel_o  = s_r.sel;
	assign edge_o = s_r.edge_st;
	assign en_o   = s_r.en;
	assign wake_o = s_r.wake;

	AST_EDGE_ONLY_BOTH: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.sel != SEL_BOTH) |=> ($stable(s_r.edge_st) || s_r.edge_st == 2'h0))
		else $error("Edge status changed outside both-edge mode.");
	AST_CLR_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
		(clr_i && !(rise || fall)) |=> s_r.edge_st == 2'h0)
		else $error("Clear did not reset edge status.");
	AST_RISE_REC: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.en && s_r.sel == SEL_BOTH && rise) |=> s_r.edge_st[0])
		else $error("Rising edge not recorded.");
	AST_DISABLED: assert property (@(posedge clk_i) disable iff (rst_i)
		!s_r.en |=> !s_r.wake)
		else $error("Wake while disabled.");
	AST_LEVEL_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.en && s_r.sel == SEL_LOW && !src_i) |=> s_r.wake)
		else $error("Low level did not wake.");
	AST_RISE_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
		($past(s_r.sel) == SEL_RISE && s_r.wake) |-> $past(src_i) && !$past(s_r.prev))
		else $error("Rising wake without rising edge.");
	COV_BOTH_FALL: cover property (@(posedge clk_i) s_r.sel == SEL_BOTH && fall && s_r.en);
endmodule

// ---- rtl/wake_source_mode.sv ----
// Purpose: Wishbone register block configuring four standby wake sources.
// Assumes: Classic Wishbone, one-cycle registered ack, inputs synchronous.
// Notes:   Wake events set sticky status bits that drive irq_o.
`timescale 1ns/1ps
module wake_source_mode
	import wake_cfg_pkg::*;
#(
	parameter int N = NUM_SRC
)
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [N-1:0] src_i,
	output logic [N-1:0]     wake_o,
	output logic             irq_o
);
	typedef struct packed {
		logic [31:0]  dat;
		logic         ack;
		logic [N-1:0] sts;
		logic [N-1:0] ien;
		logic [N-1:0] wake;
		logic         irq;
	} top_state_t;

	top_state_t   t_r;
	top_state_t   t_nxt;
	logic         req;
	logic         wr;
	logic [N-1:0] sel_we;
	logic [N-1:0] en_we;
	logic [N-1:0] clr;
	logic [N-1:0] en_q;
	logic [N-1:0] wk;
	logic [2:0]   sel_q [N];
	logic [1:0]   edge_q [N];
	logic [31:0]  mode_rd;
	logic [4:0]   clr_code;

	//--------------------------------------------------------------
	// Bus decode
	//--------------------------------------------------------------
	assign req      = wb_cyc_i & wb_stb_i & ~t_r.ack;
	assign wr       = req & wb_we_i;
	assign clr_code = wb_dat_i[4:0];

	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			// Same-write change of select and enable is software's fault; both land.
			sel_we[i] = wr && wb_adr_i == OFS_MODE && wb_sel_i[i];
			en_we[i]  = sel_we[i];
			clr[i]    = wr && wb_adr_i == OFS_CLEAR && wb_sel_i[0]
				&& clr_code == FIRST_SRC_CODE + 5'(i);
		end
	end

	//--------------------------------------------------------------
	// Source cells
	//--------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : gen_src
			wake_detector u_det (
				.clk_i    (clk_i),
				.rst_i    (rst_i),
				.src_i    (src_i[g]),
				.sel_we_i (sel_we[g]),
				.sel_i    (wb_dat_i[g*LANE_W+SEL_LSB +: 3]),
				.en_we_i  (en_we[g]),
				.en_i     (wb_dat_i[g*LANE_W+EN_BIT]),
				.clr_i    (clr[g]),
				.sel_o    (sel_q[g]),
				.edge_o   (edge_q[g]),
				.en_o     (en_q[g]),
				.wake_o   (wk[g])
			);
		end
	endgenerate

	//--------------------------------------------------------------
	// Read data
	//--------------------------------------------------------------
	// Unmapped offsets and the write-only clear register read as zero.
	always_comb
	begin
		mode_rd = '0;
		for (int i = 0; i < N; i++)
		begin
			mode_rd[i*LANE_W+SEL_LSB +: 3]  = sel_q[i];
			mode_rd[i*LANE_W+EDGE_LSB +: 2] = edge_q[i];
			mode_rd[i*LANE_W+EN_BIT]        = en_q[i];
		end
	end

	//--------------------------------------------------------------
	// Register state
	//--------------------------------------------------------------
	always_comb
	begin
		t_nxt      = t_r;
		t_nxt.ack  = req;
		t_nxt.wake = wk;
		if (wr && wb_adr_i == OFS_IRQ_EN && wb_sel_i[0])
			t_nxt.ien = wb_dat_i[N-1:0];
		if (wr && wb_adr_i == OFS_CLEAR && wb_sel_i[0])
			t_nxt.sts = t_r.sts & ~clr;
		// An event in the clear cycle wins, so it is never lost.
		t_nxt.sts = t_nxt.sts | wk;
		t_nxt.irq = |(t_nxt.sts & t_nxt.ien);
		t_nxt.dat = '0;
		if (req && !wb_we_i)
		begin
			if (wb_adr_i == OFS_MODE)
				t_nxt.dat = mode_rd;
			else if (wb_adr_i == OFS_STATUS)
				t_nxt.dat[N-1:0] = t_r.sts;
			else if (wb_adr_i == OFS_IRQ_EN)
				t_nxt.dat[N-1:0] = t_r.ien;
			else
				t_nxt.dat = '0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			t_r <= '0;
		else
			t_r <= t_nxt;
	end

	//--------------------------------------------------------------
	// Outputs
	//--------------------------------------------------------------
	assign wb_dat_o = t_r.dat;
	assign wb_ack_o = t_r.ack;
	assign wake_o   = t_r.wake;
	assign irq_o    = t_r.irq;

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	// Bus handshake: one registered ack per taken request, never more.
	AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("Ack held two cycles.");

	AST_ACK_AFTER_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
		req |=> wb_ack_o)
		else $error("Request not acknowledged in the next cycle.");

	AST_ACK_ONLY_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
		!req |=> !wb_ack_o)
		else $error("Ack without a request.");

	AST_MODE_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && wb_adr_i == OFS_MODE && wb_sel_i[1]) |=> sel_q[1] == $past(wb_dat_i[14:12]))
		else $error("Source 9 select not at bits 14-12.");

	AST_MODE_LANE3: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && wb_adr_i == OFS_MODE && wb_sel_i[3]) |=> sel_q[3] == $past(wb_dat_i[30:28]))
		else $error("Source 11 select not at bits 30-28.");

	AST_MODE_EN: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && wb_adr_i == OFS_MODE && wb_sel_i[0]) |=> en_q[0] == $past(wb_dat_i[EN_BIT]))
		else $error("Source 8 enable not at bit 0.");

	AST_SEL_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		!sel_we[2] |=> $stable(sel_q[2]))
		else $error("Source 10 select changed without a write.");

	// Read data stands with ack and reflects the state at the take edge.
	AST_READ_STS: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == OFS_STATUS) |=> wb_dat_o == 32'($past(t_r.sts)))
		else $error("Status read data wrong.");

	AST_READ_UNMAPPED: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i != OFS_MODE && wb_adr_i != OFS_STATUS
			&& wb_adr_i != OFS_IRQ_EN) |=> wb_dat_o == 32'h0)
		else $error("Unmapped read not zero.");

	// Sticky status: events set it, only the clear register takes it down.
	AST_WAKE_PIPE: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> wake_o == $past(wk))
		else $error("Release output does not follow the detector.");

	AST_STS_SET: assert property (@(posedge clk_i) disable iff (rst_i)
		(|wk) |=> ((t_r.sts & $past(wk)) == $past(wk)))
		else $error("Event did not set status.");

	AST_STS_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		!(|clr) |=> ((t_r.sts & $past(t_r.sts)) == $past(t_r.sts)))
		else $error("Status dropped without a clear.");

	AST_STS_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
		(|(clr & ~wk)) |=> ((t_r.sts & $past(clr & ~wk)) == '0))
		else $error("Clear did not reset status.");

	AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
		(wk[0] && t_nxt.ien[0]) |=> irq_o)
		else $error("Enabled event did not raise irq.");

	AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |-> irq_o == |(t_r.sts & t_r.ien))
		else $error("Irq does not match enabled status.");

	COV_WRITE:      cover property (@(posedge clk_i) wr && wb_adr_i == OFS_MODE);
	COV_CLEAR:      cover property (@(posedge clk_i) |clr);
	COV_IRQ:        cover property (@(posedge clk_i) irq_o);
	COV_LANE3_WAKE: cover property (@(posedge clk_i) wake_o[3]);
endmodule

// ---- verif/wake_src_model.sv ----
// Purpose: Drives the four wake source pins like external inputs.
// Assumes: Pins reach the block in step with clk_i.
// Notes:   Levels asked by the bench appear one edge later.
`timescale 1ns/1ps
module wake_src_model
(
	input  wire logic       clk_i,
	input  wire logic [3:0] level_i,
	output logic [3:0]      src_o
);
	always_ff @(posedge clk_i)
	begin
		src_o <= level_i;
	end
endmodule

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the wake source mode block.
// Assumes: One-cycle registered ack.
// Notes:   Select codes 101-111 are never written.
`timescale 1ns/1ps
module tb;
	import wake_cfg_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [3:0]  lvl = 4'h0;
	logic [31:0] dat_o;
	logic        ack;
	logic [3:0]  src;
	logic [3:0]  wake;
	logic        irq;
	int          failures = 0;
	int          checked = 0;
	logic [2:0]  t_code [7] = '{SEL_LOW, SEL_HIGH, SEL_FALL, SEL_RISE, SEL_RISE, SEL_RISE, SEL_BOTH};
	logic [3:0]  t_vec [7] = '{4'hB, 4'h7, 4'hB, 4'h7, 4'hA, 4'h4, 4'h7};

	always #12.5 clk_i = ~clk_i;

	wake_src_model pins (.clk_i(clk_i), .level_i(lvl), .src_o(src));
	wake_source_mode dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .src_i(src), .wake_o(wake), .irq_o(irq));

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
		begin
			failures++;
			report_and_stop;
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, s, d, q);
	endtask

	task automatic watch(output logic [3:0] w);
		w = 4'h0;
		repeat (5)
		begin
			@(negedge clk_i);
			w = w | wake;
		end
	endtask

	task automatic reset_values;
		logic [31:0] q;
		wb(1'b0, OFS_MODE, 4'hF, 32'h0, q);
		chk("mode reset", q & 32'h7D7D7D7D, 32'h20202020);
		chk("wake reset", 32'(wake), 32'h0);
		chk("irq reset", 32'(irq), 32'h0);
		wb(1'b0, OFS_STATUS, 4'hF, 32'h0, q);
		chk("status reset", q, 32'h0);
		wr(4'h2, 4'hF, 32'hFFFFFFFF);
		wb(1'b0, 4'h2, 4'hF, 32'h0, q);
		chk("unmapped", q, 32'h0);
	endtask

	// Each entry: level before, level after, enable, wake expected.
	task automatic mode_table;
		logic [31:0] q;
		logic [3:0]  w;
		logic [2:0]  pc;
		pc = SEL_RESET;
		for (int i = 0; i < 7; i++)
		begin
			lvl[2] <= t_vec[i][3];
			wr(OFS_MODE, 4'h4, 32'(pc) << 20);
			wr(OFS_MODE, 4'h4, 32'(t_code[i]) << 20);
			wr(OFS_MODE, 4'h4, (32'(t_code[i]) << 20) | (32'(t_vec[i][1]) << 16));
			lvl[2] <= t_vec[i][2];
			watch(w);
			chk("wake", 32'(w[2]), 32'(t_vec[i][0]));
			wb(1'b0, OFS_MODE, 4'hF, 32'h0, q);
			chk("edge", 32'(q[19:18]), (t_code[i] == SEL_BOTH) ? 32'h1 : 32'h0);
			pc = t_code[i];
		end
	endtask

	task automatic both_edges;
		logic [31:0] q;
		logic [3:0]  w;
		wr(OFS_MODE, 4'h1, 32'h40);
		wr(OFS_MODE, 4'h1, 32'h41);
		lvl[0] <= 1'b1;
		watch(w);
		chk("wake8", 32'(w[0]), 32'h1);
		wb(1'b0, OFS_MODE, 4'hF, 32'h0, q);
		chk("rise", 32'(q[7:0] & 8'hFD), 32'h45);
		chk("irq masked", 32'(irq), 32'h0);
		wr(OFS_IRQ_EN, 4'h1, 32'h1);
		repeat (3) @(posedge clk_i);
		chk("irq", 32'(irq), 32'h1);
		lvl[0] <= 1'b0;
		watch(w);
		chk("wake8 fall", 32'(w[0]), 32'h1);
		wb(1'b0, OFS_MODE, 4'hF, 32'h0, q);
		chk("both", 32'(q[7:0] & 8'hFD), 32'h4D);
		wb(1'b0, OFS_STATUS, 4'hF, 32'h0, q);
		chk("status set", q, 32'h5);
		wr(OFS_CLEAR, 4'h1, 32'h08);
		wb(1'b0, OFS_MODE, 4'hF, 32'h0, q);
		chk("cleared", 32'(q[7:0] & 8'hFD), 32'h41);
		wb(1'b0, OFS_STATUS, 4'hF, 32'h0, q);
		chk("status", q, 32'h4);
		repeat (3) @(posedge clk_i);
		chk("irq off", 32'(irq), 32'h0);
	endtask

	task automatic upper_lanes;
		logic [31:0] q;
		logic [3:0]  w;
		wr(OFS_MODE, 4'hA, 32'h10001000);
		wr(OFS_MODE, 4'hA, 32'h11001100);
		lvl[1] <= 1'b1;
		lvl[3] <= 1'b1;
		watch(w);
		chk("wake9 wake11", 32'(w), 32'hA);
		wb(1'b0, OFS_MODE, 4'hF, 32'h0, q);
		chk("lanes", q & 32'h7D7D7D7D, 32'h11451141);
		lvl[1] <= 1'b0;
		lvl[3] <= 1'b0;
		wb(1'b0, OFS_STATUS, 4'hF, 32'h0, q);
		chk("status upper", q, 32'hE);
		wr(OFS_CLEAR, 4'h1, 32'h0B);
		wr(OFS_CLEAR, 4'h1, 32'h0A);
		wb(1'b0, OFS_STATUS, 4'hF, 32'h0, q);
		chk("status cleared", q, 32'h2);
		wb(1'b0, OFS_MODE, 4'hF, 32'h0, q);
		chk("lane 10 cleared", q & 32'h7D7D7D7D, 32'h11411141);
		wb(1'b0, OFS_IRQ_EN, 4'hF, 32'h0, q);
		chk("irq enable", q, 32'h1);
	endtask

	task automatic report_and_stop;
		$display("Checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_i);
		failures++;
		report_and_stop;
	end

	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		reset_values;
		mode_table;
		both_edges;
		upper_lanes;
		report_and_stop;
	end
endmodule
